// ### logic/wake_consts.vh
// Constants for the wake and power-good sequencer: register offsets,
// control field positions, reset values and delay times.
// Assumes inclusion by bare name from the design files.
`ifndef WAKE_CONSTS_VH
`define WAKE_CONSTS_VH

// ==================================================================
// Register offsets.
`define OFF_WAKE_CONTROL 8'hE0
`define OFF_PASSWORD_INDEX 8'hE1
`define OFF_PASSWORD_DATA 8'hE2
`define OFF_DELAY_MOUSE_CONTROL 8'hE6

// ==================================================================
// Field positions in wake_control.
`define WC_ANY_KEY 0
`define WC_SINGLE_CLICK 1
`define WC_RIGHT_BUTTON 4
`define WC_MOUSE_EN 5
`define WC_KEY_EN 6

// Field positions in delay_and_mouse_control.
`define DC_EXTRA_LO 1
`define DC_EXTRA_HI 2
`define DC_FIRST_STAGE 3
`define DC_MOUSE_ANY 7

// ==================================================================
// Reset values.
`define WAKE_CONTROL_RESET 8'h01
`define DELAY_CONTROL_RESET 8'h00

// ==================================================================
// Password storage windows and key code values.
`define PW_SET_LEN 15
`define PW_BASE0 8'h00
`define PW_BASE1 8'h30
`define PW_BASE2 8'h40
`define BREAK_PREFIX 8'hF0
`define EMPTY_KEY 8'h00

// ==================================================================
// Delay times in milliseconds and the clock period in nanoseconds.
`define CLK_PERIOD_NS 40
`define RESUME_DELAY_MS 200
`define PG_FIRST_SLOW_MS 400
`define PG_FIRST_FAST_MS 250
`define PG_EXTRA1_MS 32
`define PG_EXTRA2_MS 96
`define PG_EXTRA3_MS 250
`define MS_TO_CYCLES(ms) ((ms) * 1000000 / `CLK_PERIOD_NS)

`endif

// ### logic/delay_timer.v
// Delay timer: an output rises after its qualifying input has held high
// for a chosen number of cycles and falls at once when the input drops.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module delay_timer #(
  parameter W = 24
) (
  // Clock and reset.
  input wire mclk,
  input wire srst,
  // Control.
  input wire valid_in,
  input wire [W-1:0] limit,
  // Result.
  output reg done_q
);

  reg [W-1:0] cnt_q;

  // Count while valid, restart from zero on a drop, finish at the limit.
  always @(posedge mclk) begin
    if (srst || !valid_in) begin
      cnt_q <= {W{1'b0}};
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (cnt_q >= limit) begin
        done_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ### logic/mouse_wake_detect.v
// Mouse wake detector: decodes three-byte mouse packets and reports a
// one-cycle wake pulse for the selected button or movement pattern.
// Assumes one byte strobe per received mouse byte, packet-aligned.
`timescale 1ns/1ps
module mouse_wake_detect (
  // Clock and reset.
  input wire mclk,
  input wire srst,
  // Mode selection.
  input wire enable,
  input wire any_event,
  input wire right_sel,
  input wire single_sel,
  // Mouse byte stream.
  input wire byte_valid,
  input wire [7:0] byte_data,
  // Result.
  output reg wake_q
);

  reg [1:0] pos_q;
  reg [7:0] head_q;
  reg moved_q;
  reg prev_btn_q;
  reg [1:0] clicks_q;
  reg last_q;
  wire btn;
  wire pressed;
  wire any_btn_press;

  assign btn = right_sel ? head_q[1] : head_q[0];
  assign pressed = btn && !prev_btn_q;
  assign any_btn_press = (head_q[1:0] != 2'b00) && !last_q;

  // Collect packets and judge each complete one.
  always @(posedge mclk) begin
    wake_q <= 1'b0;
    if (srst || !enable) begin
      pos_q <= 2'd0;
      head_q <= 8'h00;
      moved_q <= 1'b0;
      prev_btn_q <= 1'b0;
      clicks_q <= 2'd0;
      last_q <= 1'b0;
    end else if (byte_valid) begin
      if (pos_q == 2'd0) begin
        head_q <= byte_data;
        moved_q <= 1'b0;
        pos_q <= 2'd1;
      end else if (pos_q == 2'd1) begin
        moved_q <= (byte_data != 8'h00);
        pos_q <= 2'd2;
      end else begin
        pos_q <= 2'd0;
        last_q <= (head_q[1:0] != 2'b00);
        prev_btn_q <= btn;
        if (any_event) begin
          if (single_sel) begin
            wake_q <= (head_q[2:0] != 3'b000) || moved_q || (byte_data != 8'h00); // [R8]
          end else begin
            wake_q <= any_btn_press; // [R8]
          end
        end else if (pressed) begin
          if (single_sel || clicks_q == 2'd1) begin
            wake_q <= 1'b1; // [R9]
            clicks_q <= 2'd0;
          end else begin
            clicks_q <= 2'd1; // [R9]
          end
        end
      end
    end
  end

endmodule

// ### logic/wake_power_seq.v
// Wake and power-good sequencer: keyboard and mouse wake onto the power
// switch output, resume reset and power-good with programmable delays.
// Assumes supply comparators and keyboard/mouse byte strobes arrive
// synchronous to mclk, which runs free from standby power.
//
// Overview of operation
// R1: An enabled keyboard or mouse wake event pulses the power switch output low.
// R2: Keyboard wake works only while wake control bit 6 is one.
// R3: Wake control bit 0 selects any key (one) or password (zero).
// R4: Three password sets reached by index and data registers.
// R5: Each key entry is a make code then break prefix and make code.
// R6: Software pads unused password bytes after the last key with zero.
// R7: Mouse wake works only while wake control bit 5 is one.
// R8: With mouse any-event set, bit 1 picks any activity or one click.
// R9: Otherwise bit 4 picks left or right, bit 1 one or two clicks.
// R10: Resume reset rises at most 200 ms after standby supply valid.
// R11: Resume reset falls at once when standby supply drops.
// R12: Power-good rises after programmed delay once both main supplies valid.
// R13: Power-good falls at once when the main supplies drop.
// R14: Delay control bit 3 picks first stage 300-500 or 200-300 ms.
// R15: Delay control bits 2:1 add none, 32, 96 or 250 ms.
// R16: Total power-good delay is first stage plus extra, in sequence.
// R17: Power switch output stays low while the power button is held low.
// R18: Password mode wakes only on a full in-order matching key sequence.
// R19: Wake pulse width is a parameter in clock cycles.
// R20: Delay counters restart from zero when supply valid drops early.
`timescale 1ns/1ps
`include "wake_consts.vh"
module wake_power_seq #(
  parameter PULSE_CYCLES = 16,
  parameter CW = 24,
  parameter [CW-1:0] RESUME_CYCLES = `MS_TO_CYCLES(`RESUME_DELAY_MS),
  parameter [CW-1:0] PG_SLOW_CYCLES = `MS_TO_CYCLES(`PG_FIRST_SLOW_MS),
  parameter [CW-1:0] PG_FAST_CYCLES = `MS_TO_CYCLES(`PG_FIRST_FAST_MS),
  parameter [CW-1:0] PG_X1_CYCLES = `MS_TO_CYCLES(`PG_EXTRA1_MS),
  parameter [CW-1:0] PG_X2_CYCLES = `MS_TO_CYCLES(`PG_EXTRA2_MS),
  parameter [CW-1:0] PG_X3_CYCLES = `MS_TO_CYCLES(`PG_EXTRA3_MS)
) (
  // Clock and reset.
  input wire mclk,
  input wire srst,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  // Keyboard and mouse received bytes.
  input wire kbd_valid,
  input wire [7:0] kbd_data,
  input wire mouse_valid,
  input wire [7:0] mouse_data,
  // Supply comparators and power button.
  input wire standby_supply,
  input wire main_5v_supply,
  input wire main_3v_supply,
  input wire power_button_in_n,
  // Outputs to the chipset.
  output reg power_switch_out_n,
  output reg resume_reset_n,
  output reg power_good
);

  // ================================================================
  // Local definitions.
  localparam [7:0] SET_LEN = `PW_SET_LEN;
  localparam ST_MAKE = 2'd0;
  localparam ST_PREFIX = 2'd1;
  localparam ST_BREAK = 2'd2;
  localparam PG_IDLE = 2'd0;
  localparam PG_FIRST = 2'd1;
  localparam PG_EXTRA = 2'd2;
  localparam PG_ON = 2'd3;

  // Maps a password index to a flat storage slot, or 6'h3F if unmapped.
  function [5:0] slot_of;
    input [7:0] idx;
    begin
      if (idx < SET_LEN) begin
        slot_of = idx[5:0];
      end else if (idx >= `PW_BASE1 && idx < `PW_BASE1 + SET_LEN) begin
        slot_of = idx[5:0] - 6'h30 + 6'd15;
      end else if (idx >= `PW_BASE2 && idx < `PW_BASE2 + SET_LEN) begin
        slot_of = idx[5:0] + 6'd30;
      end else begin
        slot_of = 6'h3F;
      end
    end
  endfunction

  // ================================================================
  // Registers.
  reg [7:0] wake_ctl_q;
  reg [7:0] pw_index_q;
  reg [7:0] delay_ctl_q;
  reg [7:0] pw_mem [0:44];
  reg [1:0] pw_set_q;
  wire [5:0] wr_slot;

  assign wr_slot = slot_of(pw_index_q);

  // Register writes; the index also picks the set the matcher uses.
  always @(posedge mclk) begin
    if (srst) begin
      wake_ctl_q <= `WAKE_CONTROL_RESET;
      pw_index_q <= 8'h00;
      delay_ctl_q <= `DELAY_CONTROL_RESET;
      pw_set_q <= 2'd0;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFF_WAKE_CONTROL: wake_ctl_q <= reg_wdata;
        `OFF_PASSWORD_INDEX: begin
          pw_index_q <= reg_wdata; // [R4]
          if (slot_of(reg_wdata) != 6'h3F) begin
            pw_set_q <= (slot_of(reg_wdata) < 6'd15) ? 2'd0 :
                        (slot_of(reg_wdata) < 6'd30) ? 2'd1 : 2'd2;
          end
        end
        `OFF_DELAY_MOUSE_CONTROL: delay_ctl_q <= reg_wdata;
        default: pw_index_q <= pw_index_q;
      endcase
    end
  end

  // Password storage written through the data register.
  genvar gi;
  generate
    for (gi = 0; gi < 45; gi = gi + 1) begin : g_pw
      always @(posedge mclk) begin
        if (srst) begin
          pw_mem[gi] <= `EMPTY_KEY;
        end else if (reg_wr && reg_addr == `OFF_PASSWORD_DATA && wr_slot == gi) begin
          pw_mem[gi] <= reg_wdata; // [R4]
        end
      end
    end
  endgenerate

  // Read data, valid in the cycle after the read strobe; unmapped reads 0.
  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFF_WAKE_CONTROL: reg_rdata_q <= wake_ctl_q;
        `OFF_PASSWORD_INDEX: reg_rdata_q <= pw_index_q;
        `OFF_PASSWORD_DATA: reg_rdata_q <= (wr_slot == 6'h3F) ? 8'h00 : pw_mem[wr_slot];
        `OFF_DELAY_MOUSE_CONTROL: reg_rdata_q <= delay_ctl_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ================================================================
  // Keyboard wake: any key or stored password.
  reg [1:0] kst_q;
  reg [3:0] kpos_q;
  reg kwake_q;
  reg byte_ok;
  wire key_en;
  wire [5:0] kslot;
  wire [7:0] want;
  wire [7:0] next_want;
  wire at_end;

  assign key_en = wake_ctl_q[`WC_KEY_EN]; // [R2]
  assign kslot = {2'b00, kpos_q} + (pw_set_q == 2'd0 ? 6'd0 :
                 pw_set_q == 2'd1 ? 6'd15 : 6'd30);
  assign want = pw_mem[kslot];
  assign next_want = (kslot == 6'd44) ? `EMPTY_KEY : pw_mem[kslot + 6'd1];
  // Zero padding after a complete break code ends the stored sequence.
  assign at_end = (kst_q == ST_BREAK) &&
                  ((kpos_q == 4'd14) || (next_want == `EMPTY_KEY)); // [R6]

  // Each stored byte is one received byte: make code, break prefix, make code.
  always @* begin
    case (kst_q)
      ST_MAKE: byte_ok = (kbd_data == want) && (want != `EMPTY_KEY) &&
                         (want != `BREAK_PREFIX);
      ST_PREFIX: byte_ok = (kbd_data == `BREAK_PREFIX) && (want == `BREAK_PREFIX); // [R5]
      ST_BREAK: byte_ok = (kbd_data == want); // [R5]
      default: byte_ok = 1'b0;
    endcase
  end

  // Walks the stored bytes in order; a wrong byte restarts at the first key.
  always @(posedge mclk) begin
    kwake_q <= 1'b0;
    if (srst || !key_en) begin
      kst_q <= ST_MAKE;
      kpos_q <= 4'd0;
    end else if (wake_ctl_q[`WC_ANY_KEY]) begin
      kwake_q <= kbd_valid; // [R3]
      kst_q <= ST_MAKE;
      kpos_q <= 4'd0;
    end else if (kbd_valid) begin
      if (!byte_ok) begin
        kst_q <= ST_MAKE;
        kpos_q <= 4'd0;
      end else if (at_end) begin
        kwake_q <= 1'b1; // [R18]
        kst_q <= ST_MAKE;
        kpos_q <= 4'd0;
      end else begin
        kpos_q <= kpos_q + 4'd1; // [R18]
        case (kst_q)
          ST_MAKE: kst_q <= ST_PREFIX;
          ST_PREFIX: kst_q <= ST_BREAK;
          default: kst_q <= ST_MAKE;
        endcase
      end
    end
  end

  // ================================================================
  // Mouse wake.
  wire mwake;

  mouse_wake_detect u_mouse (
    .mclk(mclk),
    .srst(srst),
    .enable(wake_ctl_q[`WC_MOUSE_EN]), // [R7]
    .any_event(delay_ctl_q[`DC_MOUSE_ANY]),
    .right_sel(wake_ctl_q[`WC_RIGHT_BUTTON]),
    .single_sel(wake_ctl_q[`WC_SINGLE_CLICK]),
    .byte_valid(mouse_valid),
    .byte_data(mouse_data),
    .wake_q(mwake)
  );

  // ================================================================
  // Power switch output: wake pulse of fixed width, or button follow.
  reg [15:0] pulse_q;

  always @(posedge mclk) begin
    if (srst) begin
      pulse_q <= 16'h0000;
      power_switch_out_n <= 1'b1;
    end else begin
      if (kwake_q || mwake) begin
        pulse_q <= PULSE_CYCLES[15:0]; // [R19]
      end else if (pulse_q != 16'h0000) begin
        pulse_q <= pulse_q - 16'h0001;
      end
      // Low while the pulse runs or the button is held.
      power_switch_out_n <= !(kwake_q || mwake || pulse_q > 16'h0001) &&
                            power_button_in_n; // [R1] [R17]
    end
  end

  // ================================================================
  // Resume reset from the standby supply.
  wire rs_done;

  delay_timer #(.W(CW)) u_resume (
    .mclk(mclk),
    .srst(srst),
    .valid_in(standby_supply), // [R20]
    .limit(RESUME_CYCLES),
    .done_q(rs_done)
  );

  always @(posedge mclk) begin
    if (srst) begin
      resume_reset_n <= 1'b0;
    end else begin
      resume_reset_n <= rs_done && standby_supply; // [R10] [R11]
    end
  end

  // ================================================================
  // Power-good: first stage then extra stage, sequenced.
  reg [1:0] pg_st_q;
  reg [CW-1:0] pg_cnt_q;
  wire mains_ok;
  reg [CW-1:0] first_lim;
  reg [CW-1:0] extra_lim;

  assign mains_ok = main_5v_supply && main_3v_supply;

  // Stage limits from the delay control register.
  always @* begin
    first_lim = delay_ctl_q[`DC_FIRST_STAGE] ? PG_FAST_CYCLES : PG_SLOW_CYCLES; // [R14]
    case (delay_ctl_q[`DC_EXTRA_HI:`DC_EXTRA_LO])
      2'b01: extra_lim = PG_X1_CYCLES; // [R15]
      2'b10: extra_lim = PG_X2_CYCLES;
      2'b11: extra_lim = PG_X3_CYCLES;
      default: extra_lim = {CW{1'b0}};
    endcase
  end

  always @(posedge mclk) begin
    if (srst || !mains_ok) begin
      pg_st_q <= PG_IDLE; // [R13] [R20]
      pg_cnt_q <= {CW{1'b0}};
      power_good <= 1'b0;
    end else begin
      case (pg_st_q)
        PG_IDLE: begin
          pg_st_q <= PG_FIRST; // [R12]
          pg_cnt_q <= {CW{1'b0}};
        end
        PG_FIRST: begin
          if (pg_cnt_q >= first_lim) begin
            pg_st_q <= PG_EXTRA; // [R16]
            pg_cnt_q <= {CW{1'b0}};
          end else begin
            pg_cnt_q <= pg_cnt_q + {{(CW-1){1'b0}}, 1'b1};
          end
        end
        PG_EXTRA: begin
          if (pg_cnt_q >= extra_lim) begin
            pg_st_q <= PG_ON;
            power_good <= 1'b1; // [R12]
          end else begin
            pg_cnt_q <= pg_cnt_q + {{(CW-1){1'b0}}, 1'b1};
          end
        end
        PG_ON: power_good <= 1'b1;
        default: pg_st_q <= PG_IDLE;
      endcase
    end
  end

endmodule

// ### bench/wake_seq_chk_sva.sv
// Port-level checker for the wake and power-good sequencer.
// Assumes its delay parameters are those of the bound design instance.
`timescale 1ns/1ps
module wake_seq_chk #(
  parameter RESUME_CYCLES = 20,
  parameter PG_SLOW_CYCLES = 40,
  parameter PG_FAST_CYCLES = 30,
  parameter PG_X1_CYCLES = 5,
  parameter PG_X2_CYCLES = 10,
  parameter PG_X3_CYCLES = 15
) (
  // Clock and reset.
  input wire mclk,
  input wire srst,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  // Byte strobes, supplies and button.
  input wire kbd_valid,
  input wire mouse_valid,
  input wire standby_supply,
  input wire main_5v_supply,
  input wire main_3v_supply,
  input wire power_button_in_n,
  // Outputs under check.
  input wire power_switch_out_n,
  input wire resume_reset_n,
  input wire power_good
);
  reg [15:0] sb_q;
  reg [15:0] mn_q;
  reg [3:0] act_q;
  reg [7:0] dc_q;
  integer xtra;
  integer pg_exp;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ==================================================================
  // Helper logic
  // Counts cycles of valid supplies and since the last byte; shadows the delay register.
  always @(posedge mclk) begin
    if (srst) begin
      sb_q <= 16'h0000;
      mn_q <= 16'h0000;
      act_q <= 4'hF;
      dc_q <= 8'h00;
    end else begin
      sb_q <= standby_supply ? sb_q + 16'h0001 : 16'h0000;
      mn_q <= (main_5v_supply && main_3v_supply) ? mn_q + 16'h0001 : 16'h0000;
      act_q <= (kbd_valid || mouse_valid) ? 4'h0 : act_q + {3'h0, act_q != 4'hF};
      if (reg_wr && reg_addr == 8'hE6) begin
        dc_q <= reg_wdata;
      end
    end
  end

  // Expected power-good delay: first stage plus the extra stage.
  always @* begin
    xtra = dc_q[2] ? (dc_q[1] ? PG_X3_CYCLES : PG_X2_CYCLES) : (dc_q[1] ? PG_X1_CYCLES : 0);
    pg_exp = xtra + (dc_q[3] ? PG_FAST_CYCLES : PG_SLOW_CYCLES);
  end

  // ==================================================================
  // Assertions
  // A wake pulse holds low a few cycles, then ends.
  sequence low_s;
    !power_switch_out_n [*3];
  endsequence
  rsm_drop_a: assert property (!standby_supply |=> !resume_reset_n)
    else $error("resume reset high without standby supply");
  pg_drop_a: assert property (!(main_5v_supply && main_3v_supply) |=> !power_good)
    else $error("power good high without both main supplies");
  rsm_rise_a: assert property ($rose(resume_reset_n) |->
    sb_q >= RESUME_CYCLES && sb_q <= RESUME_CYCLES + 6)
    else $error("resume reset rose at the wrong time");
  rsm_late_a: assert property (sb_q == RESUME_CYCLES + 7 |-> resume_reset_n)
    else $error("resume reset late");
  pg_rise_a: assert property ($rose(power_good) |->
    mn_q >= pg_exp && mn_q <= pg_exp + 6)
    else $error("power good rose at the wrong time");
  pg_late_a: assert property (mn_q == pg_exp + 7 |-> power_good)
    else $error("power good late");
  button_follow_a: assert property (!power_button_in_n |=> !power_switch_out_n)
    else $error("switch output not following button");
  wake_cause_a: assert property ($fell(power_switch_out_n) |->
    !$past(power_button_in_n) || act_q < 4'h4)
    else $error("switch output fell without cause");
  pulse_width_a: assert property ($fell(power_switch_out_n) && power_button_in_n |->
    low_s ##[1:6] power_switch_out_n)
    else $error("wake pulse width wrong");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data outside read slot");
endmodule

bind wake_power_seq wake_seq_chk #(
  .RESUME_CYCLES(RESUME_CYCLES), .PG_SLOW_CYCLES(PG_SLOW_CYCLES),
  .PG_FAST_CYCLES(PG_FAST_CYCLES), .PG_X1_CYCLES(PG_X1_CYCLES),
  .PG_X2_CYCLES(PG_X2_CYCLES), .PG_X3_CYCLES(PG_X3_CYCLES)
) chk_u (
  .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .kbd_valid(kbd_valid), .mouse_valid(mouse_valid),
  .standby_supply(standby_supply), .main_5v_supply(main_5v_supply),
  .main_3v_supply(main_3v_supply), .power_button_in_n(power_button_in_n),
  .power_switch_out_n(power_switch_out_n), .resume_reset_n(resume_reset_n),
  .power_good(power_good)
);

// ### bench/kbd_mouse_src.sv
// Behavioural source of keyboard and mouse bytes for the sequencer.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/1ps
module kbd_mouse_src (
  // Clock.
  input wire mclk,
  // Keyboard bytes.
  output reg kbd_valid,
  output reg [7:0] kbd_data,
  // Mouse bytes.
  output reg mouse_valid,
  output reg [7:0] mouse_data
);
  // Idle outputs from time zero.
  initial begin
    kbd_valid = 1'b0;
    kbd_data = 8'hA5;
    mouse_valid = 1'b0;
    mouse_data = 8'h5A;
  end

  // One strobed byte, then a gap; idle data shows no stale byte.
  task send(input bit mouse, input [7:0] b);
    begin
      if (mouse) begin
        mouse_valid <= 1'b1;
        mouse_data <= b;
      end else begin
        kbd_valid <= 1'b1;
        kbd_data <= b;
      end
      @(posedge mclk);
      kbd_valid <= 1'b0;
      mouse_valid <= 1'b0;
      kbd_data <= ~kbd_data;
      mouse_data <= ~mouse_data;
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the wake and power-good sequencer.
// Assumes shortened delay parameters set at the instance below.
`timescale 1ns/1ps
module testbench;
  reg mclk;
  reg srst;
  reg [7:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  wire [7:0] reg_rdata_q;
  wire kbd_valid;
  wire [7:0] kbd_data;
  wire mouse_valid;
  wire [7:0] mouse_data;
  reg standby_supply;
  reg main_5v_supply;
  reg main_3v_supply;
  reg power_button_in_n;
  wire power_switch_out_n;
  wire resume_reset_n;
  wire power_good;
  integer fail_count;
  integer compares;
  integer i;
  integer j;
  integer n;
  integer e;
  reg s;
  reg [7:0] pw [0:5];
  reg [31:0] mt [0:5];
  // Shortened delays in clock cycles, so that every power sequence fits the run.
  localparam [23:0] RSM_CYC = 24'd20;
  localparam [23:0] SLOW_CYC = 24'd40;
  localparam [23:0] FAST_CYC = 24'd30;
  localparam [23:0] X1_CYC = 24'd5;
  localparam [23:0] X2_CYC = 24'd10;
  localparam [23:0] X3_CYC = 24'd15;

  // ==================================================================
  // Instances
  wake_power_seq #(.PULSE_CYCLES(4), .RESUME_CYCLES(RSM_CYC), .PG_SLOW_CYCLES(SLOW_CYC),
    .PG_FAST_CYCLES(FAST_CYC), .PG_X1_CYCLES(X1_CYC), .PG_X2_CYCLES(X2_CYC),
    .PG_X3_CYCLES(X3_CYC)) dut_u (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .kbd_valid(kbd_valid), .kbd_data(kbd_data), .mouse_valid(mouse_valid),
    .mouse_data(mouse_data), .standby_supply(standby_supply),
    .main_5v_supply(main_5v_supply), .main_3v_supply(main_3v_supply),
    .power_button_in_n(power_button_in_n), .power_switch_out_n(power_switch_out_n),
    .resume_reset_n(resume_reset_n), .power_good(power_good));
  kbd_mouse_src src_u (.mclk(mclk), .kbd_valid(kbd_valid), .kbd_data(kbd_data),
    .mouse_valid(mouse_valid), .mouse_data(mouse_data));

  // Free-running 25 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ==================================================================
  // Tasks
  // Compares and counts.
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task results;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Register write, then one idle cycle.
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
    end
  endtask
  // Register read; data stands in the following cycle only.
  task rd(input [7:0] a, input [7:0] x);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      chk(reg_rdata_q, x);
    end
  endtask
  // Counts edges until resume reset or power-good rises, bounded.
  task wait_rise(input bit pg, output integer c);
    begin
      c = 0;
      while ((pg ? power_good : resume_reset_n) !== 1'b1) begin
        @(posedge mclk);
        c = c + 1;
        if (c > 200) begin
          fail_count = fail_count + 1;
          results;
        end
      end
    end
  endtask
  // Sends one mouse packet and checks whether a wake pulse follows.
  task pkt(input [7:0] b0, input bit x);
    begin
      src_u.send(1'b1, b0);
      src_u.send(1'b1, 8'h05);
      src_u.send(1'b1, 8'h00);
      s = 1'b0;
      repeat (12) begin
        @(posedge mclk);
        s = s | (power_switch_out_n === 1'b0);
      end
      chk(s, x);
    end
  endtask
  // Keyboard byte sequence, then a pulse watch.
  task keys(input integer cnt, input [7:0] last, input bit x);
    begin
      for (j = 0; j < cnt; j = j + 1)
        src_u.send(1'b0, j == cnt - 1 ? last : pw[j]);
      s = 1'b0;
      repeat (20) begin
        @(posedge mclk);
        s = s | (power_switch_out_n === 1'b0);
      end
      chk(s, x);
    end
  endtask

  // ==================================================================
  // Main sequence
  initial begin
    fail_count = 0;
    compares = 0;
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    standby_supply = 1'b0;
    main_5v_supply = 1'b0;
    main_3v_supply = 1'b0;
    power_button_in_n = 1'b1;
    pw[0] = 8'h45;
    pw[1] = 8'hF0;
    pw[2] = 8'h45;
    pw[3] = 8'h16;
    pw[4] = 8'hF0;
    pw[5] = 8'h16;
    mt[0] = 32'h80220809;
    mt[1] = 32'h8020080A;
    mt[2] = 32'h00220A09;
    mt[3] = 32'h0032090A;
    mt[4] = 32'h00200909;
    mt[5] = 32'h00300A0A;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(8'hE0, 8'h01);
    rd(8'hE6, 8'h00);
    wr(8'hE3, 8'h5A);
    rd(8'hE3, 8'h00);
    wr(8'hE1, 8'h0E);
    rd(8'hE1, 8'h0E);
    wr(8'hE2, 8'hC3);
    rd(8'hE2, 8'hC3);
    $display("test registers done");
    standby_supply <= 1'b1;
    repeat (10) @(posedge mclk);
    standby_supply <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(resume_reset_n, 0);
    standby_supply <= 1'b1;
    wait_rise(1'b0, n);
    chk((n >= RSM_CYC && n <= RSM_CYC + 6) ? RSM_CYC[15:0] : n[15:0], RSM_CYC[15:0]);
    standby_supply <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(resume_reset_n, 0);
    standby_supply <= 1'b1;
    wait_rise(1'b0, n);
    main_5v_supply <= 1'b1;
    repeat (60) @(posedge mclk);
    chk(power_good, 0);
    main_5v_supply <= 1'b0;
    $display("test resume reset done");
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'hE6, {4'h0, i[2:0], 1'b0});
      main_5v_supply <= 1'b1;
      main_3v_supply <= 1'b1;
      wait_rise(1'b1, n);
      e = (i[2] ? FAST_CYC : SLOW_CYC) + (i[1:0] == 2'd1 ? X1_CYC :
        i[1:0] == 2'd2 ? X2_CYC : i[1:0] == 2'd3 ? X3_CYC : 24'd0);
      chk((n >= e && n <= e + 6) ? e[15:0] : n[15:0], e[15:0]);
      main_5v_supply <= i[0];
      main_3v_supply <= !i[0];
      repeat (2) @(posedge mclk);
      chk(power_good, 0);
      main_5v_supply <= 1'b0;
      main_3v_supply <= 1'b0;
      @(posedge mclk);
    end
    $display("test power good done");
    wr(8'hE0, 8'h01);
    keys(1, 8'h1C, 1'b0);
    wr(8'hE0, 8'h41);
    keys(1, 8'h1C, 1'b1);
    for (i = 0; i < 15; i = i + 1) begin
      wr(8'hE1, 8'h30 + i[7:0]);
      wr(8'hE2, i < 6 ? pw[i] : 8'h00);
    end
    wr(8'hE0, 8'h40);
    keys(6, 8'h1E, 1'b0);
    keys(6, 8'h16, 1'b1);
    $display("test keyboard done");
    power_button_in_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(power_switch_out_n, 0);
    power_button_in_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(power_switch_out_n, 1);
    $display("test button done");
    wr(8'hE6, 8'h80);
    wr(8'hE0, 8'h02);
    pkt(8'h09, 1'b0);
    for (i = 0; i < 6; i = i + 1) begin
      srst <= 1'b1;
      @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      wr(8'hE6, mt[i][31:24]);
      wr(8'hE0, mt[i][23:16]);
      pkt(mt[i][15:8], i == 0);
      pkt(8'h08, i == 0);
      pkt(mt[i][7:0], 1'b1);
    end
    $display("test mouse done");
    results;
  end
endmodule
